// ### common/idle_inc_jump_consts.vh
`ifndef IDLE_INC_JUMP_CONSTS_VH
`define IDLE_INC_JUMP_CONSTS_VH

// opcodes
`define OPC_IDLE        8'h6F
`define OPC_INC_R       8'h20
`define OPC_INC_IR      8'h21
`define OPC_INCREMENT_WORD_OP_RR     8'hA0
`define OPC_INCREMENT_WORD_OP_IR     8'hA1
`define OPC_RETURN_FROM_INTERRUPT_OP        8'hBF
`define OPC_JP_IRR      8'h30
`define NIB_INC_WR      4'hE
`define NIB_JP_DA       4'hD
`define NIB_JR_RA       4'hB

// instruction cycle counts
`define CYC_IDLE        5'd4
`define CYC_INC         5'd4
`define CYC_INCREMENT_WORD_OP        5'd8
`define CYC_RETURN_FROM_INTERRUPT_OP_INT    5'd10
`define CYC_RETURN_FROM_INTERRUPT_OP_EXT    5'd12
`define CYC_RETURN_FROM_INTERRUPT_OP_FAST   5'd6
`define CYC_JP          5'd8
`define CYC_JR          5'd6

// register addresses
`define ADDR_FLAGS      8'hD5
`define ADDR_SYM        8'hDE
`define ADDR_SP         8'hD9
`define ADDR_STACK_CFG  8'hD0

// flag bit positions, and the enable bit of sym
`define FLG_C           7
`define FLG_Z           6
`define FLG_S           5
`define FLG_V           4
`define FLG_D           3
`define FLG_H           2
`define FLG_FIS         1
`define SYM_GIE         0

// reset values
`define RST_FLAGS       8'h00
`define RST_SYM         8'h00
`define RST_SP          8'hFF
`define RST_PC          16'h0000
`define RST_IP          16'h0100

`endif

// ### core/cond_eval.v
`timescale 1ns/1ps
`include "idle_inc_jump_consts.vh"
// registered condition evaluation against flags
module cond_eval (
    input  wire       i_clk,
    input  wire       i_rst_n,
    input  wire [3:0] i_cc,
    input  wire [7:0] i_flags,
    output reg        o_true
);
    wire c = i_flags[`FLG_C];   // carry
    wire z = i_flags[`FLG_Z];   // zero
    wire s = i_flags[`FLG_S];   // sign
    wire v = i_flags[`FLG_V];   // overflow
    reg  t;                      // combinational result

    // standard sixteen-entry table
    always @* begin
        case (i_cc)
            4'h0:    t = 1'b0;
            4'h1:    t = s ^ v;
            4'h2:    t = z | (s ^ v);
            4'h3:    t = c | z;
            4'h4:    t = v;
            4'h5:    t = s;
            4'h6:    t = z;
            4'h7:    t = c;
            4'h8:    t = 1'b1;
            4'h9:    t = ~(s ^ v);
            4'hA:    t = ~(z | (s ^ v));
            4'hB:    t = ~(c | z);
            4'hC:    t = ~v;
            4'hD:    t = ~s;
            4'hE:    t = ~z;
            default: t = ~c;
        endcase
    end

    // register result
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_true <= 1'b0;
        end else begin
            o_true <= t;
        end
    end
endmodule

// ### core/exec_idle_inc_jump.v
`timescale 1ns/1ps
`include "idle_inc_jump_consts.vh"
module exec_idle_inc_jump (
    input  wire        i_clk,
    input  wire        i_rst_n,
    input  wire [7:0]  i_pm_data,
    input  wire        i_irq,
    input  wire        i_ext_stack,
    input  wire [7:0]  i_addr,
    input  wire [7:0]  i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [7:0]  o_rdata,
    output reg  [15:0] o_pm_addr,
    output reg  [15:0] o_pc,
    output reg  [15:0] o_ip,
    output reg  [7:0]  o_flags,
    output reg  [7:0]  o_sym,
    output reg  [7:0]  o_sp,
    output reg         o_cpu_clk_en,
    output reg         o_busy
);
    // states
    localparam ST_FETCH = 3'd0;
    localparam ST_OPND  = 3'd1;
    localparam ST_OPND2 = 3'd2;
    localparam ST_READ  = 3'd3;
    localparam ST_EXEC  = 3'd4;
    localparam ST_WAIT  = 3'd5;
    localparam ST_IDLE  = 3'd6;

    reg [2:0]  state_r;        // sequencer state
    reg [7:0]  opc_r;          // current opcode
    reg [7:0]  op1_r;          // first operand byte
    reg [7:0]  op2_r;          // second operand byte
    reg [4:0]  cyc_r;          // cycles used this instruction
    reg [4:0]  len_r;          // cycles owed for this instruction
    reg [1:0]  step_r;         // read step within ST_READ
    reg [7:0]  shadow_r;       // shadow flags for fast service
    reg [7:0]  ind_r;          // indirect address latch
    reg        irq_m_r;        // irq sync stage one
    reg        irq_s_r;        // irq sync stage two
    reg        xs_m_r;         // stack strap sync one
    reg        xs_s_r;         // stack strap sync two

    // memory ports
    reg        we_a;
    reg  [7:0] addr_a;
    reg  [7:0] wd_a;
    reg        we_b;
    reg  [7:0] addr_b;
    reg  [7:0] wd_b;
    wire [7:0] rd_a;
    wire [7:0] rd_b;
    wire       cc_true;

    // opcode nibble split
    wire [3:0] hi_nib = opc_r[7:4];
    wire [3:0] lo_nib = opc_r[3:0];

    // working register address in bank c0
    function [7:0] wr_addr;
        input [3:0] r;
        begin
            wr_addr = {4'hC, r};
        end
    endfunction

    // flag update for increment results
    function [7:0] inc_flags;
        input [7:0] f;
        input       zero;
        input       neg;
        input       ovf;
        begin
            inc_flags = f;
            inc_flags[`FLG_Z] = zero;
            inc_flags[`FLG_S] = neg;
            inc_flags[`FLG_V] = ovf;
        end
    endfunction

    reg_file_mem #(.AW(8), .DW(8)) u_mem (
        .i_clk     (i_clk),
        .i_we_a    (we_a),
        .i_addr_a  (addr_a),
        .i_wdata_a (wd_a),
        .o_rdata_a (rd_a),
        .i_we_b    (we_b),
        .i_addr_b  (addr_b),
        .i_wdata_b (wd_b),
        .o_rdata_b (rd_b)
    );

    cond_eval u_cond (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_cc    (hi_nib),
        .i_flags (o_flags),
        .o_true  (cc_true)
    );

    // pin synchronisers
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_m_r <= 1'b0;
            irq_s_r <= 1'b0;
            xs_m_r  <= 1'b0;
            xs_s_r  <= 1'b0;
        end else begin
            irq_m_r <= i_irq;
            irq_s_r <= irq_m_r;
            xs_m_r  <= i_ext_stack;
            xs_s_r  <= xs_m_r;
        end
    end

    // instruction class decode
    wire is_inc_wr = (lo_nib == `NIB_INC_WR);
    wire is_inc    = (opc_r == `OPC_INC_R) || (opc_r == `OPC_INC_IR);
    wire is_increment_word_op   = (opc_r == `OPC_INCREMENT_WORD_OP_RR) || (opc_r == `OPC_INCREMENT_WORD_OP_IR);
    wire is_jp     = (lo_nib == `NIB_JP_DA);
    wire is_jr     = (lo_nib == `NIB_JR_RA);
    wire is_fast   = o_flags[`FLG_FIS];
    wire is_ind    = (opc_r == `OPC_INC_IR) || (opc_r == `OPC_INCREMENT_WORD_OP_IR);

    // increment results
    wire [7:0]  inc8   = rd_a + 8'h01;
    wire [15:0] word   = {rd_a, rd_b};
    wire [15:0] inc16  = word + 16'h0001;
    wire [15:0] pc_rel = o_pc + {{8{op1_r[7]}}, op1_r};

    // memory port steering
    always @* begin
        we_a   = 1'b0;
        wd_a   = 8'h00;
        we_b   = 1'b0;
        wd_b   = 8'h00;
        addr_a = ind_r;
        addr_b = {ind_r[7:1], 1'b1};
        if (state_r == ST_READ) begin
            if (opc_r == `OPC_RETURN_FROM_INTERRUPT_OP) begin
                addr_a = o_sp;
                addr_b = o_sp + 8'h01;
            end else if (is_inc_wr) begin
                addr_a = wr_addr(hi_nib);
            end else if (opc_r == `OPC_JP_IRR) begin
                addr_a = {op1_r[7:1], 1'b0};
                addr_b = {op1_r[7:1], 1'b1};
            end else if (is_ind && step_r != 2'd0) begin
                addr_a = ind_r;                   // operand at fetched pointer
                addr_b = {ind_r[7:1], 1'b1};
            end else begin
                addr_a = op1_r;                   // direct operand or pointer reg
                addr_b = {op1_r[7:1], 1'b1};
            end
        end else if (state_r == ST_EXEC) begin
            if (is_inc_wr || is_inc) begin
                we_a = 1'b1;
                wd_a = inc8;
            end else if (is_increment_word_op) begin
                we_a   = 1'b1;
                wd_a   = inc16[15:8];
                we_b   = 1'b1;
                wd_b   = inc16[7:0];
                addr_a = {ind_r[7:1], 1'b0};
            end else if (opc_r == `OPC_RETURN_FROM_INTERRUPT_OP) begin
                addr_a = o_sp + 8'h02;            // pc low byte for second pass
            end
        end
    end

    // sequencer and architectural state
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r      <= ST_FETCH;
            opc_r        <= 8'h00;
            op1_r        <= 8'h00;
            op2_r        <= 8'h00;
            cyc_r        <= 5'd0;
            len_r        <= 5'd0;
            step_r       <= 2'd0;
            ind_r        <= 8'h00;
            shadow_r     <= `RST_FLAGS;
            o_pc         <= `RST_PC;
            o_ip         <= `RST_IP;
            o_flags      <= `RST_FLAGS;
            o_sym        <= `RST_SYM;
            o_sp         <= `RST_SP;
            o_pm_addr    <= `RST_PC;
            o_cpu_clk_en <= 1'b1;
            o_busy       <= 1'b0;
            o_rdata      <= 8'h00;
        end else begin
            cyc_r <= cyc_r + 5'd1;
            // register port write, hardware update applied below wins
            if (i_wr && i_addr == `ADDR_FLAGS) begin
                o_flags <= i_wdata;
            end
            if (i_wr && i_addr == `ADDR_SYM) begin
                o_sym <= i_wdata;
            end
            if (i_wr && i_addr == `ADDR_SP) begin
                o_sp <= i_wdata;
            end
            if (i_wr && i_addr == `ADDR_STACK_CFG) begin
                shadow_r <= i_wdata;
            end
            // register port read, data one cycle later
            case (i_addr)
                `ADDR_FLAGS:     o_rdata <= i_rd ? o_flags : 8'h00;
                `ADDR_SYM:       o_rdata <= i_rd ? o_sym : 8'h00;
                `ADDR_SP:        o_rdata <= i_rd ? o_sp : 8'h00;
                `ADDR_STACK_CFG: o_rdata <= i_rd ? shadow_r : 8'h00;
                default:         o_rdata <= 8'h00;
            endcase
            case (state_r)
                ST_FETCH: begin
                    opc_r     <= i_pm_data;
                    o_pc      <= o_pc + 16'h0001;
                    o_pm_addr <= o_pc + 16'h0001;
                    cyc_r     <= 5'd1;
                    step_r    <= 2'd0;
                    o_busy    <= 1'b1;
                    state_r   <= ST_OPND;
                end
                ST_OPND: begin
                    if (opc_r == `OPC_IDLE) begin
                        o_cpu_clk_en <= 1'b0;
                        len_r        <= `CYC_IDLE;
                        state_r      <= ST_IDLE;
                    end else if (opc_r == `OPC_RETURN_FROM_INTERRUPT_OP) begin
                        len_r   <= is_fast ? `CYC_RETURN_FROM_INTERRUPT_OP_FAST :
                                   (xs_s_r ? `CYC_RETURN_FROM_INTERRUPT_OP_EXT : `CYC_RETURN_FROM_INTERRUPT_OP_INT);
                        state_r <= is_fast ? ST_EXEC : ST_READ;
                    end else if (is_inc_wr) begin
                        len_r   <= `CYC_INC;
                        state_r <= ST_READ;
                    end else if (is_inc || is_increment_word_op || is_jr ||
                                 opc_r == `OPC_JP_IRR || is_jp) begin
                        op1_r     <= i_pm_data;
                        o_pc      <= o_pc + 16'h0001;
                        o_pm_addr <= o_pc + 16'h0001;
                        len_r     <= is_inc ? `CYC_INC : is_increment_word_op ? `CYC_INCREMENT_WORD_OP :
                                     is_jr ? `CYC_JR : `CYC_JP;
                        state_r   <= is_jp ? ST_OPND2 : (is_jr ? ST_EXEC : ST_READ);
                    end else begin
                        // not this group: skip
                        len_r   <= 5'd2;
                        state_r <= ST_WAIT;
                    end
                end
                ST_OPND2: begin
                    op2_r     <= i_pm_data;
                    o_pc      <= o_pc + 16'h0001;
                    o_pm_addr <= o_pc + 16'h0001;
                    state_r   <= ST_EXEC;
                end
                ST_READ: begin
                    step_r <= step_r + 2'd1;
                    if (step_r == 2'd1) begin
                        ind_r   <= is_ind ? rd_a : addr_a;
                        state_r <= is_ind ? ST_READ : ST_EXEC;
                    end else if (step_r == 2'd3) begin
                        state_r <= ST_EXEC;
                    end
                    if (step_r == 2'd1 && !is_ind) begin
                        state_r <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state_r <= ST_WAIT;
                    if (is_inc_wr || is_inc) begin
                        o_flags <= inc_flags(o_flags, inc8 == 8'h00, inc8[7],
                                             rd_a == 8'h7F);
                    end else if (is_increment_word_op) begin
                        o_flags <= inc_flags(o_flags, inc16 == 16'h0000, inc16[15],
                                             word == 16'h7FFF);
                    end else if (opc_r == `OPC_RETURN_FROM_INTERRUPT_OP && step_r == 2'd3) begin
                        o_pc      <= {o_pc[15:8], rd_a};
                        o_pm_addr <= {o_pc[15:8], rd_a};
                    end else if (opc_r == `OPC_RETURN_FROM_INTERRUPT_OP && is_fast) begin
                        // swap and shadow restore, fis cleared
                        o_pc      <= o_ip;
                        o_ip      <= o_pc;
                        o_pm_addr <= o_ip;
                        o_flags   <= {shadow_r[7:2], 1'b0, shadow_r[0]};
                    end else if (opc_r == `OPC_RETURN_FROM_INTERRUPT_OP) begin
                        o_flags   <= rd_a;
                        o_sp      <= o_sp + 8'h03;
                        o_pc      <= {rd_b, o_pc[7:0]};
                        o_sym     <= o_sym | 8'h01;
                        step_r    <= 2'd3;        // marks the low-byte pass
                        state_r   <= ST_EXEC;
                    end else if (opc_r == `OPC_JP_IRR) begin
                        o_pc      <= {rd_a, rd_b};
                        o_pm_addr <= {rd_a, rd_b};
                    end else if (is_jp && cc_true) begin
                        o_pc      <= {op1_r, op2_r};
                        o_pm_addr <= {op1_r, op2_r};
                    end else if (is_jr && cc_true) begin
                        o_pc      <= pc_rel;
                        o_pm_addr <= pc_rel;
                    end
                end
                ST_WAIT: begin
                    if (cyc_r + 5'd1 >= len_r) begin
                        o_busy  <= 1'b0;
                        state_r <= ST_FETCH;
                    end
                end
                ST_IDLE: begin
                    // count held once served, so a long sleep never wraps it
                    if (cyc_r >= len_r) begin
                        cyc_r <= len_r;
                    end
                    if (irq_s_r && cyc_r + 5'd1 >= len_r) begin
                        o_cpu_clk_en <= 1'b1;
                        o_busy       <= 1'b0;
                        state_r      <= ST_FETCH;
                    end
                end
                default: state_r <= ST_FETCH;
            endcase
        end
    end
endmodule

// ### core/reg_file_mem.v
`timescale 1ns/1ps
`include "idle_inc_jump_consts.vh"
// general register file: two ports, registered read data
module reg_file_mem #(
    parameter AW = 8,
    parameter DW = 8
) (
    input  wire          i_clk,
    input  wire          i_we_a,
    input  wire [AW-1:0] i_addr_a,
    input  wire [DW-1:0] i_wdata_a,
    output reg  [DW-1:0] o_rdata_a,
    input  wire          i_we_b,
    input  wire [AW-1:0] i_addr_b,
    input  wire [DW-1:0] i_wdata_b,
    output reg  [DW-1:0] o_rdata_b
);
    reg [DW-1:0] mem [0:(1<<AW)-1];   // storage

    // both ports in one process, so the store has a single driver
    always @(posedge i_clk) begin
        if (i_we_a) begin
            mem[i_addr_a] <= i_wdata_a;
        end
        if (i_we_b) begin
            mem[i_addr_b] <= i_wdata_b;
        end
        o_rdata_a <= mem[i_addr_a];
        o_rdata_b <= mem[i_addr_b];
    end
endmodule

// ### tb/exec_idle_inc_jump_asserts.sv
`timescale 1ns/1ps
// port watcher for the executor: idle gating, returns and register port
module exec_checker (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_irq,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  o_rdata,
    input  wire logic [15:0] o_pc,
    input  wire logic [15:0] o_ip,
    input  wire logic [7:0]  o_flags,
    input  wire logic [7:0]  o_sym,
    input  wire logic [7:0]  o_sp,
    input  wire logic        o_cpu_clk_en,
    input  wire logic        o_busy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    chk_reset_values: assert property ($rose(i_rst_n) |-> o_pc == 16'h0000
        && o_ip == 16'h0100 && o_sp == 8'hFF && o_cpu_clk_en) else $error("bad reset state");
    chk_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read slot");
    chk_rdata_flags: assert property (i_rd && i_addr == 8'hD5 |=> o_rdata == $past(o_flags))
        else $error("flag read mismatch");
    chk_idle_hold: assert property (!o_cpu_clk_en && !i_irq && !$past(i_irq)
        && !$past(i_irq, 2) |=> !o_cpu_clk_en) else $error("idle left without request");
    chk_idle_wake: assert property (!o_cpu_clk_en && i_irq |-> ##[1:6] o_cpu_clk_en)
        else $error("idle not left on request");
    chk_idle_frozen: assert property (!o_cpu_clk_en && !$past(o_cpu_clk_en)
        |-> $stable(o_pc) && $stable(o_flags)) else $error("state moved while idle");
    chk_sp_steps: assert property ($changed(o_sp) && !$past(i_wr)
        |-> 8'(o_sp - $past(o_sp)) inside {8'h01, 8'h02, 8'h03}) else $error("bad stack step");
    chk_sym_source: assert property ($changed(o_sym) && !$past(i_wr) |-> o_sym[0])
        else $error("mode changed without enable");
    chk_fis_clears: assert property ($changed(o_ip) |-> ##[0:6] !o_flags[1])
        else $error("fast bit left set");
    chk_fast_stack: assert property ($changed(o_ip) |-> o_sp == $past(o_sp))
        else $error("fast return moved stack");
    chk_busy_ends: assert property ($rose(o_busy) |-> ##[1:40] (!o_busy || !o_cpu_clk_en))
        else $error("instruction never ends");
    cov_idle: cover property ($fell(o_cpu_clk_en));
    cov_fast: cover property ($changed(o_ip));
    cov_normal: cover property ($rose(o_sym[0]) && !$past(i_wr));
    cov_read: cover property (i_rd && i_addr == 8'hD5);
endmodule

bind exec_idle_inc_jump exec_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_irq(i_irq),
    .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .o_rdata(o_rdata), .o_pc(o_pc), .o_ip(o_ip),
    .o_flags(o_flags), .o_sym(o_sym), .o_sp(o_sp), .o_cpu_clk_en(o_cpu_clk_en),
    .o_busy(o_busy));

// ### tb/prog_mem.sv
`timescale 1ns/1ps
// program memory: answers the fetch address in the same cycle
module prog_mem (
    input  wire logic [15:0] i_addr,
    output logic      [7:0]  o_data
);
    logic [7:0] mem [0:65535];  // byte store, loaded by the bench
    assign o_data = mem[i_addr];
    // fill with a byte outside the group, so gaps are skipped
    task automatic clear();
        for (int a = 0; a < 65536; a++) begin
            mem[a] = 8'hFF;
        end
    endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
`include "idle_inc_jump_consts.vh"
module tb_top;
    logic        i_clk;
    logic        i_rst_n;
    logic        i_irq;
    logic        i_ext_stack;
    logic [7:0]  i_addr;
    logic [7:0]  i_wdata;
    logic        i_wr;
    logic        i_rd;
    wire  [7:0]  i_pm_data;
    wire  [7:0]  o_rdata;
    wire  [15:0] o_pm_addr;
    wire  [15:0] o_pc;
    wire  [15:0] o_ip;
    wire  [7:0]  o_flags;
    wire  [7:0]  o_sym;
    wire  [7:0]  o_sp;
    wire         o_cpu_clk_en;
    wire         o_busy;
    integer      n_mismatch = 0;
    integer      cmp_count = 0;
    integer      cycles = 0;
    integer      seed = 32'h4090;
    integer      j;
    logic        hit;
    logic [7:0]  rv;
    logic [7:0]  op_t [0:6] = '{8'h8B, 8'h8B, 8'h0B, 8'h7B, 8'h8D, 8'h0D, 8'h8B};
    logic [7:0]  b1_t [0:6] = '{8'h7F, 8'h80, 8'h7F, 8'h7F, 8'h12, 8'h12, 8'h00};

    exec_idle_inc_jump uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pm_data(i_pm_data),
        .i_irq(i_irq), .i_ext_stack(i_ext_stack), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pm_addr(o_pm_addr), .o_pc(o_pc),
        .o_ip(o_ip), .o_flags(o_flags), .o_sym(o_sym), .o_sp(o_sp),
        .o_cpu_clk_en(o_cpu_clk_en), .o_busy(o_busy));
    prog_mem u_pm (.i_addr(o_pm_addr), .o_data(i_pm_data));

    // condition table of the model, flags as given
    function automatic logic cond_true(input logic [3:0] cc, input logic [7:0] f);
        case (cc)
            4'h8: return 1'b1;
            4'h7: return f[`FLG_C];
            4'h6: return f[`FLG_Z];
            4'h5: return f[`FLG_S];
            4'h4: return f[`FLG_V];
            default: return 1'b0;
        endcase
    endfunction
    // model of the landing address after one jump at 0000
    function automatic logic [15:0] expect_pc(input logic [7:0] op, input logic [7:0] b1);
        logic [15:0] nxt;
        nxt = (op[3:0] == `NIB_JP_DA) ? 16'h0003 : 16'h0002;
        if (!cond_true(op[7:4], `RST_FLAGS)) return nxt + 16'h0001;
        if (op[3:0] == `NIB_JP_DA) return {b1, 8'h34};
        return nxt + {{8{b1[7]}}, b1};
    endfunction
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_of_test();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        check(name, exp, o_rdata);
    endtask
    task automatic restart();
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
    endtask
    // bounded wait for a fetch address
    task automatic wait_pm(input logic [15:0] a, input integer lim);
        hit = 1'b0;
        for (int n = 0; n < lim && !hit; n++) begin
            @(posedge i_clk);
            #1;
            if (o_pm_addr === a) hit = 1'b1;
        end
    endtask
    // loop at 0000 until carry is written, then run the byte at 0004
    task automatic gate_prog(input logic [7:0] b);
        u_pm.clear();
        u_pm.mem[0] = 8'h7B;
        u_pm.mem[1] = 8'h02;
        u_pm.mem[2] = 8'h8B;
        u_pm.mem[3] = 8'hFC;
        u_pm.mem[4] = b;
        restart();
    endtask

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    // hang guard
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial begin
        {i_rst_n, i_irq, i_ext_stack, i_wr, i_rd} = 5'h00;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        u_pm.clear();
        repeat (16) @(posedge i_clk);
        check("reset sp", `RST_SP, o_sp);
        check("reset ip", `RST_IP, o_ip);
        i_rst_n <= 1'b1;
        rv = 8'($random(seed)) & 8'h7C;
        wr(`ADDR_FLAGS, rv);
        rd(`ADDR_FLAGS, rv, "flag register"); // readback
        rd(8'hD7, 8'h00, "unmapped read");
        for (j = 0; j < 7; j++) begin
            if (j == 6) b1_t[6] = {2'b10, 6'($random(seed))};
            u_pm.clear();
            u_pm.mem[0] = op_t[j];
            u_pm.mem[1] = b1_t[j];
            u_pm.mem[2] = 8'h34;
            restart();
            wait_pm(expect_pc(op_t[j], b1_t[j]), 80);
            check("jump landing", 16'h0001, {15'h0000, hit}); // landing
        end
        rv = 8'($random(seed)) | 8'h02;
        gate_prog(`OPC_RETURN_FROM_INTERRUPT_OP);
        wr(`ADDR_STACK_CFG, rv);
        wr(`ADDR_FLAGS, 8'h82);
        wait_pm(16'h0100, 100);
        check("fast return pc", 16'h0001, {15'h0000, hit}); // pc swap
        check("fast return ip", 16'h0005, o_ip); // ip swap
        repeat (2) @(posedge i_clk);
        check("fast return flags", rv & 8'hFD, o_flags); // shadow restore
        check("fast return sp", `RST_SP, o_sp); // stack untouched
        i_ext_stack <= 1'($random(seed));
        gate_prog(`OPC_RETURN_FROM_INTERRUPT_OP);
        uut.u_mem.mem[8'hFF] = rv & 8'hFD;
        uut.u_mem.mem[8'h00] = 8'h12;
        uut.u_mem.mem[8'h01] = 8'h56;
        wr(`ADDR_FLAGS, 8'h80);
        wait_pm(16'h1256, 60);
        check("normal return pc", 16'h0001, {15'h0000, hit}); // popped pc
        check("normal return flags", rv & 8'hFD, o_flags); // popped flags
        check("normal return busy", 16'h0001, {15'h0000, o_busy}); // still running
        check("normal return enable", 16'h0001, {15'h0000, o_sym[`SYM_GIE]});
        check("normal return sp", 8'h02, o_sp); // three pops
        rd(`ADDR_SP, 8'h02, "stack pointer read");
        rd(`ADDR_SYM, 8'h01, "mode read");
        gate_prog({4'h3, `NIB_INC_WR});
        uut.u_mem.mem[8'hC3] = 8'h7F;
        wr(`ADDR_FLAGS, 8'h8C);
        wait_pm(16'h0007, 60);
        check("increment keeps c d h", 8'h8C, o_flags & 8'h8C);
        check("increment flags", 8'hBC, o_flags); // sign and overflow
        check("increment result", 8'h80, uut.u_mem.mem[8'hC3]);
        // indirect, direct and word increments, then a jump through the pair
        gate_prog(`OPC_INC_IR);
        u_pm.mem[5] = 8'h50;
        u_pm.mem[6] = `OPC_INC_R;
        u_pm.mem[7] = 8'h61;
        u_pm.mem[8] = `OPC_INCREMENT_WORD_OP_RR;
        u_pm.mem[9] = 8'h40;
        u_pm.mem[10] = `OPC_JP_IRR;
        u_pm.mem[11] = 8'h40;
        uut.u_mem.mem[8'h50] = 8'h60;
        uut.u_mem.mem[8'h60] = 8'h11;
        uut.u_mem.mem[8'h61] = 8'hFE;
        uut.u_mem.mem[8'h40] = 8'h7F;
        uut.u_mem.mem[8'h41] = 8'hFF;
        wr(`ADDR_FLAGS, 8'h8C);
        wait_pm(16'h8000, 100);
        check("register pair jump", 16'h0001, {15'h0000, hit}); // landing
        check("word increment flags", 8'hBC, o_flags);
        check("indirect increment", 8'h12, uut.u_mem.mem[8'h60]);
        check("register increment", 8'hFF, uut.u_mem.mem[8'h61]);
        check("word increment low", 8'h00, uut.u_mem.mem[8'h41]);
        u_pm.clear();
        u_pm.mem[0] = `OPC_IDLE;
        restart();
        for (int n = 0; n < 30 && o_cpu_clk_en !== 1'b0; n++) @(posedge i_clk);
        repeat (20) @(posedge i_clk);
        check("idle clock gate", 16'h0000, {15'h0000, o_cpu_clk_en});
        check("idle flags", `RST_FLAGS, o_flags);
        i_irq <= 1'b1;
        for (int n = 0; n < 10 && o_cpu_clk_en !== 1'b1; n++) @(posedge i_clk);
        check("idle wake", 16'h0001, {15'h0000, o_cpu_clk_en});
        i_irq <= 1'b0;
        end_of_test();
    end
endmodule
